// file: hw/sysref_capture_calibration.sv
// reference capture windowing, phase map and automatic delay calibration
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps

// Functional notes
// R1: reference latched on one repeatable clock edge
// R2: single-channel mode captures on both edges
// R3: selectable delayed capture instants offered
// R4: reference position recorded in phase map
// R5: map one means violation, zero valid
// R6: software picks zero bit, midway preferred
// R7: step control: zero coarse, one fine
// R8: map bits 0 and 23 always one
// R9: capture select indexes bits 0 to 15
// R10: 24 map bits over three byte registers
// R11: software sets capture select zero for calibration
// R12: clock and periodic reference during calibration
// R13: write config, then set enable
// R14: search delay until falling edge meets reference
// R15: try both polarities, keep smallest coarse
// R16: found delay readable in result field
// R17: calibrated delay held until disable
// R18: software may write stored delay directly
// R19: no launch during converter calibration
// R20: invert is half period; 256 coarse, fine steps
// R21: completion flag readable by software
module sysref_capture_calibration #(
	parameter int DELAY_STEPS = 256
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// window detector: per-instant timing violation flags, and edge-aligned indication
	input wire logic [23:0] windowViolation,
	input wire logic edgeAligned,
	input wire logic singleChannel,
	input wire logic sysrefIn,
	// delay and capture controls to the analog path
	output logic clockInvertDelay,
	output logic [7:0] coarseClockDelay,
	output logic [7:0] fineClockDelay,
	output logic phaseStepFine,
	output logic [3:0] captureSelect,
	output logic dualEdgeCapture,
	output logic sysrefCaptured
);
	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	// the delay fields are eight bits wide, so only 256 settings can be served
	if (DELAY_STEPS != 256) begin : g_bad_delay_steps
		$error("DELAY_STEPS must be 256");
	end
	if (sysref_cal_pkg::CAPSEL_POSITIONS != 16 || sysref_cal_pkg::MAP_WIDTH != 24) begin : g_bad_map_size
		$error("capture select must span 16 of 24 map positions");
	end

	// ----------------------------------------
	// reset synchroniser
	// ----------------------------------------
	// asserts at once, releases only after two clock edges
	logic rstMeta_q;
	logic rstSync_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [3:0] capSel_q;
	logic stepFine_q;
	logic [7:0] calCfg_q;
	logic calEn_q;
	logic calDone_q;
	logic [16:0] result_q;
	logic manInv_q;
	logic [7:0] manCoarse_q;
	logic [7:0] manFine_q;
	logic [23:0] phaseMap_q;
	logic ack_q;
	logic [31:0] rdat_q;
	sysref_cal_pkg::cal_state_type state_q;
	// search position: polarity first, then coarse step
	logic trialInv_q;
	logic [7:0] trialCoarse_q;
	logic [7:0] settle_q;

	function automatic logic [7:0] word_index(input logic [9:0] adr);
		word_index = adr[9:2];
	endfunction : word_index

	function automatic logic [16:0] pack_delay(input logic inv, input logic [7:0] coarse, input logic [7:0] fine);
		pack_delay = {inv, coarse, fine};
	endfunction : pack_delay

	function automatic logic [31:0] map_byte(input logic [23:0] map, input logic [1:0] sel);
		map_byte = {24'h000000, map[{sel, 3'h0} +: 8]};
	endfunction : map_byte

	logic access;
	logic wrAccess;
	logic [7:0] index;
	assign access = wb_cyc_i && wb_stb_i && !ack_q;
	assign wrAccess = access && wb_we_i;
	assign index = word_index(wb_adr_i);

	// ----------------------------------------
	// phase map capture
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q)
			phaseMap_q <= sysref_cal_pkg::MAP_RESET;
		else begin
			phaseMap_q <= windowViolation; // R4 R5 R10
			// end positions lack a neighbour, so they always read as violations
			phaseMap_q[0] <= 1'b1; // R8
			phaseMap_q[sysref_cal_pkg::MAP_WIDTH-1] <= 1'b1; // R8
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			capSel_q <= sysref_cal_pkg::CAPSEL_RESET;
			stepFine_q <= sysref_cal_pkg::STEP_FINE_RESET;
			calCfg_q <= sysref_cal_pkg::AUTOCAL_CONFIG_RESET;
			calEn_q <= 1'b0;
			manInv_q <= 1'b0;
			manCoarse_q <= 8'h00;
			manFine_q <= 8'h00;
		end else if (wrAccess && wb_sel_i[0]) begin
			// writes land on the edge that takes the request; other offsets are ignored
			unique case (index)
				sysref_cal_pkg::IDX_CAPTURE_CTRL: begin
					capSel_q <= wb_dat_i[sysref_cal_pkg::CAPSEL_LSB +: 4]; // R9
					stepFine_q <= wb_dat_i[sysref_cal_pkg::STEP_FINE_BIT]; // R7
				end
				sysref_cal_pkg::IDX_AUTOCAL_CONFIG: calCfg_q <= wb_dat_i[7:0];
				sysref_cal_pkg::IDX_AUTOCAL_ENABLE: calEn_q <= wb_dat_i[sysref_cal_pkg::AUTOCAL_EN_BIT]; // R13
				sysref_cal_pkg::IDX_DELAY_CTRL: begin
					manFine_q <= wb_dat_i[sysref_cal_pkg::FINE_LSB +: 8]; // R18
					if (wb_sel_i[1])
						manCoarse_q <= wb_dat_i[sysref_cal_pkg::COARSE_LSB +: 8];
					if (wb_sel_i[2])
						manInv_q <= wb_dat_i[sysref_cal_pkg::INVERT_BIT];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// automatic calibration search
	// ----------------------------------------
	// order: coarse 0..255, each tried with invert 0 then invert 1; first hit is the smallest coarse
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			state_q <= sysref_cal_pkg::CAL_IDLE;
			trialInv_q <= 1'b0;
			trialCoarse_q <= 8'h00;
			settle_q <= 8'h00;
			calDone_q <= 1'b0;
			result_q <= 17'h00000;
		end else if (!calEn_q) begin
			// dropping enable abandons the search and clears the done flag
			state_q <= sysref_cal_pkg::CAL_IDLE;
			calDone_q <= 1'b0;
		end else begin
			unique case (state_q)
				sysref_cal_pkg::CAL_IDLE: begin
					trialInv_q <= 1'b0;
					trialCoarse_q <= 8'h00;
					settle_q <= sysref_cal_pkg::SETTLE_CYCLES;
					state_q <= sysref_cal_pkg::CAL_SETTLE; // R14
				end
				sysref_cal_pkg::CAL_SETTLE: begin
					// let the delay settle before the detector is believed
					settle_q <= settle_q - 8'h01;
					if (settle_q == 8'h01)
						state_q <= sysref_cal_pkg::CAL_CHECK;
				end
				sysref_cal_pkg::CAL_CHECK: begin
					settle_q <= sysref_cal_pkg::SETTLE_CYCLES;
					if (edgeAligned) begin
						result_q <= pack_delay(trialInv_q, trialCoarse_q, manFine_q); // R16
						calDone_q <= 1'b1; // R21
						state_q <= sysref_cal_pkg::CAL_DONE;
					end else if (!trialInv_q) begin
						trialInv_q <= 1'b1; // R15
						state_q <= sysref_cal_pkg::CAL_SETTLE;
					end else begin
						trialInv_q <= 1'b0;
						trialCoarse_q <= trialCoarse_q + 8'h01; // R15 R20
						// no hit anywhere: report zero but still flag completion
						if (trialCoarse_q == 8'hFF) begin
							result_q <= 17'h00000;
							calDone_q <= 1'b1;
							state_q <= sysref_cal_pkg::CAL_DONE;
						end else
							state_q <= sysref_cal_pkg::CAL_SETTLE;
					end
				end
				sysref_cal_pkg::CAL_DONE: state_q <= sysref_cal_pkg::CAL_DONE; // R17
				default: state_q <= sysref_cal_pkg::CAL_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// delay outputs
	// ----------------------------------------
	// searching: trial delays drive the clock path; holding: the found delay stays applied
	logic searching;
	logic holding;
	assign searching = calEn_q && (state_q != sysref_cal_pkg::CAL_DONE);
	assign holding = calEn_q && (state_q == sysref_cal_pkg::CAL_DONE);
	// the fine delay is not searched: it takes the manual value, and holding applies the copy in result_q (zero after no hit)

	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			clockInvertDelay <= 1'b0;
			coarseClockDelay <= 8'h00;
			fineClockDelay <= 8'h00;
		end else if (searching) begin
			clockInvertDelay <= trialInv_q; // R20
			coarseClockDelay <= trialCoarse_q;
			fineClockDelay <= manFine_q;
		end else if (holding) begin
			clockInvertDelay <= result_q[16]; // R17
			coarseClockDelay <= result_q[15:8];
			fineClockDelay <= result_q[7:0];
		end else begin
			clockInvertDelay <= manInv_q; // R18
			coarseClockDelay <= manCoarse_q;
			fineClockDelay <= manFine_q;
		end
	end

	// ----------------------------------------
	// capture control
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			phaseStepFine <= sysref_cal_pkg::STEP_FINE_RESET;
			captureSelect <= sysref_cal_pkg::CAPSEL_RESET;
			dualEdgeCapture <= 1'b0;
			sysrefCaptured <= 1'b0;
		end else begin
			phaseStepFine <= stepFine_q; // R7
			// calibration needs capture select at zero, so it is forced there
			captureSelect <= calEn_q ? 4'h0 : capSel_q; // R3 R9 R11
			// both captures are one-cycle registers of their inputs
			dualEdgeCapture <= singleChannel; // R2
			sysrefCaptured <= sysrefIn; // R1
		end
	end

	// ----------------------------------------
	// bus read and acknowledge
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstSync_q) begin
		if (!rstSync_q) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			// registered ack: one wait state, and a held strobe is not taken twice
			ack_q <= access;
			if (access && !wb_we_i) begin
				unique case (index)
					sysref_cal_pkg::IDX_MAP_LOW: rdat_q <= map_byte(phaseMap_q, 2'h0); // R10
					sysref_cal_pkg::IDX_MAP_MID: rdat_q <= map_byte(phaseMap_q, 2'h1);
					sysref_cal_pkg::IDX_MAP_HIGH: rdat_q <= map_byte(phaseMap_q, 2'h2);
					sysref_cal_pkg::IDX_CAPTURE_CTRL: rdat_q <= {27'h0000000, stepFine_q, capSel_q};
					sysref_cal_pkg::IDX_AUTOCAL_CONFIG: rdat_q <= {24'h000000, calCfg_q};
					sysref_cal_pkg::IDX_AUTOCAL_ENABLE: rdat_q <= {30'h00000000, calDone_q, calEn_q}; // R21
					sysref_cal_pkg::IDX_AUTOCAL_RESULT: rdat_q <= {15'h0000, result_q}; // R16
					sysref_cal_pkg::IDX_DELAY_CTRL: rdat_q <= {15'h0000, pack_delay(manInv_q, manCoarse_q, manFine_q)};
					default: rdat_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
endmodule : sysref_capture_calibration

// file: hw/sysref_cal_pkg.sv
// constants for the reference capture and calibration block
package sysref_cal_pkg;
	// register word indices (word aligned: byte offset = 4 x index)
	localparam logic [7:0] IDX_MAP_LOW = 8'h2C;
	localparam logic [7:0] IDX_MAP_MID = 8'h2D;
	localparam logic [7:0] IDX_MAP_HIGH = 8'h2E;
	localparam logic [7:0] IDX_CAPTURE_CTRL = 8'h30;
	localparam logic [7:0] IDX_AUTOCAL_CONFIG = 8'h31;
	localparam logic [7:0] IDX_AUTOCAL_ENABLE = 8'h32;
	localparam logic [7:0] IDX_AUTOCAL_RESULT = 8'h33;
	localparam logic [7:0] IDX_DELAY_CTRL = 8'h34;
	// field positions
	localparam int CAPSEL_LSB = 0;
	localparam int STEP_FINE_BIT = 4;
	localparam int AUTOCAL_EN_BIT = 0;
	localparam int AUTOCAL_DONE_BIT = 1;
	localparam int INVERT_BIT = 16;
	localparam int COARSE_LSB = 8;
	localparam int FINE_LSB = 0;
	// reset values
	localparam logic [3:0] CAPSEL_RESET = 4'h0;
	localparam logic STEP_FINE_RESET = 1'b1;
	localparam logic [7:0] AUTOCAL_CONFIG_RESET = 8'h00;
	localparam logic [23:0] MAP_RESET = 24'hFFFFFF;
	// map sizing
	localparam int MAP_WIDTH = 24;
	localparam int CAPSEL_POSITIONS = 16;
	// search settle time per trial setting, in cycles
	localparam logic [7:0] SETTLE_CYCLES = 8'h10;
	typedef enum logic [3:0] {
		CAL_IDLE = 4'b0001,
		CAL_SETTLE = 4'b0010,
		CAL_CHECK = 4'b0100,
		CAL_DONE = 4'b1000
	} cal_state_type;
endpackage : sysref_cal_pkg

// file: testbench/sysref_cal_monitor.sv
// concurrent checks on the ports of the reference capture block
`timescale 1ns/1ps
module sysref_cal_monitor (
	// watched ports
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [23:0] windowViolation,
	input wire logic singleChannel,
	input wire logic sysrefIn,
	input wire logic [7:0] coarseClockDelay,
	input wire logic dualEdgeCapture,
	input wire logic sysrefCaptured
);
	logic [2:0] up_q;
	logic [7:0] mapMid_q;
	logic take;
	// checks stay off until the internal reset copy has been released
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) up_q <= 3'h0;
		else if (up_q != 3'h4) up_q <= up_q + 3'h1;
	end
	always_ff @(posedge clk_sys) begin
		mapMid_q <= windowViolation[15:8];
	end
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n || up_q != 3'h4);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	ack_answer_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("request not acked for exactly one cycle");
	ref_capture_a: assert property (sysrefCaptured == $past(sysrefIn))
		else $error("reference not captured on the next edge");
	dual_edge_a: assert property ($changed(singleChannel) |=> dualEdgeCapture == $past(singleChannel))
		else $error("dual edge capture does not follow mode");
	map_low_edge_a: assert property (take && !wb_we_i && wb_adr_i == 10'h0B0 |=> wb_dat_o[0])
		else $error("lowest map bit not forced high");
	map_high_edge_a: assert property (take && !wb_we_i && wb_adr_i == 10'h0B8 |=> wb_dat_o[7])
		else $error("highest map bit not forced high");
	map_mid_a: assert property (take && !wb_we_i && wb_adr_i == 10'h0B4 && $stable(windowViolation)
		|=> wb_dat_o == {24'h0, mapMid_q})
		else $error("middle map byte differs from detector");
	search_settle_a: assert property ($changed(coarseClockDelay) && !wb_ack_o |=> $stable(coarseClockDelay)[*8])
		else $error("trial delay did not settle");
	unmapped_read_a: assert property (take && !wb_we_i && wb_adr_i == 10'h3FC |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule : sysref_cal_monitor

// file: testbench/clock_source_model.sv
// clock source and window detector standing in front of the block
`timescale 1ns/1ps
module clock_source_model (
	// bench controls
	input wire logic clk_sys,
	input wire logic [23:0] violPattern,
	input wire logic targetInv,
	input wire logic [7:0] targetCoarse,
	input wire logic singleMode,
	// delay applied by the block
	input wire logic clockInvertDelay,
	input wire logic [7:0] coarseClockDelay,
	// towards the block
	output logic [23:0] windowViolation,
	output logic edgeAligned,
	output logic singleChannel,
	output logic sysrefIn
);
	logic [2:0] phase_q = 3'h0;
	// periodic reference, one pulse every eight cycles
	always @(posedge clk_sys) begin
		phase_q <= phase_q + 3'h1;
	end
	assign sysrefIn = (phase_q == 3'h0);
	assign windowViolation = violPattern;
	assign edgeAligned = (clockInvertDelay == targetInv) && (coarseClockDelay == targetCoarse);
	assign singleChannel = singleMode;
endmodule : clock_source_model

// file: testbench/sysref_capture_calibration_tb.sv
// self-checking bench for the reference capture block
`timescale 1ns/1ps
module sysref_capture_calibration_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [9:0] wbAdr = 10'h000;
	logic [31:0] wbWdat = 32'h0, wbRdat, rd;
	logic wbAck, edgeAligned, singleChannel, sysrefIn, clockInvertDelay, phaseStepFine, dualEdgeCapture, sysrefCaptured;
	logic [23:0] windowViolation, violPattern = 24'h000000;
	logic [7:0] coarseClockDelay, fineClockDelay, targetCoarse = 8'h02;
	logic [3:0] captureSelect;
	logic targetInv = 1'b1, singleMode = 1'b0;
	int errCount = 0, nCompared = 0, cycles = 0;
	always #5 clk_sys = ~clk_sys;
	sysref_capture_calibration dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbWdat), .wb_dat_o(wbRdat), .wb_ack_o(wbAck),
		.windowViolation(windowViolation), .edgeAligned(edgeAligned), .singleChannel(singleChannel),
		.sysrefIn(sysrefIn), .clockInvertDelay(clockInvertDelay), .coarseClockDelay(coarseClockDelay),
		.fineClockDelay(fineClockDelay), .phaseStepFine(phaseStepFine), .captureSelect(captureSelect),
		.dualEdgeCapture(dualEdgeCapture), .sysrefCaptured(sysrefCaptured));
	clock_source_model source (.clk_sys(clk_sys), .violPattern(violPattern), .targetInv(targetInv),
		.targetCoarse(targetCoarse), .singleMode(singleMode), .clockInvertDelay(clockInvertDelay),
		.coarseClockDelay(coarseClockDelay), .windowViolation(windowViolation), .edgeAligned(edgeAligned),
		.singleChannel(singleChannel), .sysrefIn(sysrefIn));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic completeRun();
		if (errCount == 0 && nCompared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : completeRun
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			errCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// one classic cycle, held until ack is seen at a rising edge
	task automatic wbXfer(input logic we, input logic [9:0] adr, input logic [31:0] dat);
		@(posedge clk_sys);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbWdat <= dat;
		do @(posedge clk_sys); while (wbAck !== 1'b1);
		rd = wbRdat;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask : wbXfer
	task automatic rdChk(input logic [9:0] adr, input logic [31:0] exp);
		wbXfer(1'b0, adr, 32'h0);
		check(rd, exp);
	endtask : rdChk
	function automatic logic [31:0] delays();
		return {15'h0, clockInvertDelay, coarseClockDelay, fineClockDelay};
	endfunction : delays
	task automatic phaseMap();
		violPattern <= 24'h7E0318;
		singleMode <= 1'b1;
		check({27'h0, phaseStepFine, captureSelect}, 32'h10);
		rdChk(10'h0B0, 32'h19);
		rdChk(10'h0B4, 32'h03);
		rdChk(10'h0B8, 32'hFE);
		check({31'h0, dualEdgeCapture}, 32'h1);
		wbXfer(1'b1, 10'h0C0, 32'h16);
		@(negedge clk_sys);
		check({27'h0, phaseStepFine, captureSelect}, 32'h16);
	endtask : phaseMap
	task automatic selectAll();
		for (int i = 0; i < 16; i++) begin
			wbXfer(1'b1, 10'h0C0, {27'h0, i[0], i[3:0]});
			@(negedge clk_sys);
			check({27'h0, phaseStepFine, captureSelect}, {27'h0, i[0], i[3:0]});
		end
		rdChk(10'h0C0, 32'h1F);
		wbXfer(1'b1, 10'h3FC, 32'hFFFFFFFF);
		rdChk(10'h3FC, 32'h0);
	endtask : selectAll
	task automatic autoCal();
		wbXfer(1'b1, 10'h0C0, 32'h10);
		wbXfer(1'b1, 10'h0D0, 32'h010533);
		@(negedge clk_sys);
		check(delays(), 32'h010533);
		wbXfer(1'b1, 10'h0C4, 32'h5A);
		rdChk(10'h0C4, 32'h5A);
		wbXfer(1'b1, 10'h0C8, 32'h1);
		rd = 32'h0;
		for (int n = 0; n < 100 && rd[1] !== 1'b1; n++) wbXfer(1'b0, 10'h0C8, 32'h0);
		check(rd, 32'h3);
		rdChk(10'h0CC, 32'h010233);
		check(delays(), 32'h010233);
		wbXfer(1'b1, 10'h0C8, 32'h0);
		rdChk(10'h0C8, 32'h0);
		check(delays(), 32'h010533);
	endtask : autoCal
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		phaseMap();
		selectAll();
		autoCal();
		completeRun();
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			errCount++;
			completeRun();
		end
	end
endmodule : sysref_capture_calibration_tb
bind sysref_capture_calibration sysref_cal_monitor monitor (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .windowViolation, .singleChannel, .sysrefIn, .coarseClockDelay,
	.dualEdgeCapture, .sysrefCaptured);
